/* File: src/reset_timeout_sequencer.sv */
// reset time-out sequencer with its power status register on apb
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "rts_consts.svh"

// Function
// - power-on pulse starts the time-out sequence
// - power-up delay of 72 ms after power-on
// - chip held in reset while delay runs
// - delay counts ticks of internal rc oscillator
// - disable bit skips the power-up delay after power-on only
// - then 1024 oscillator pin cycles held
// - start-up timer only crystal modes, power-on/brown-out/wake
// - rc mode, delay disabled: no time-out
// - order: power-on, power-up delay, start-up timer
// - enable bit turns brown-out reset on
// - sustained supply dip below level resets chip
// - after brown-out recovery run 72 ms delay
// - dip during delay re-enters brown-out, restarts
// - time-outs run regardless of master clear
// - bit0 cleared by brown-out, software sets
// - bit0 undefined when brown-out is disabled
// - bit1 cleared on power-on only, software sets
// - power-on sets timeout and powerdown flags
// - flags encode watchdog and master clear causes
// - wake-up: crystal 1024 cycles, rc none
module reset_timeout_sequencer #(
    parameter int unsigned DELAY_TICKS = `DELAY_TICKS
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic POWERON_PULSE_I,
    input wire logic SUPPLY_LOW_I,
    input wire logic MASTER_CLEAR_N_I,
    input wire logic OSC_INPUT_PIN_I,
    input wire logic SLEEP_I,
    input wire logic WDT_TIMEOUT_I,
    input wire logic INT_WAKE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [`ADDR_W-1:0] PADDR_I,
    input wire logic [`DATA_W-1:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [`DATA_W-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic CHIP_RESET_O,
    output logic TIMEOUT_FLAG_O,
    output logic POWERDOWN_FLAG_O
);

    localparam logic [6:0] RC_TICK_LAST = 7'(`RC_TICK_CYCLES - 1);
    localparam logic [16:0] DELAY_LAST = 17'(DELAY_TICKS - 1);
    localparam logic [10:0] START_LAST = 11'(`START_CYCLES - 1);
    localparam logic [3:0] DIP_MIN = 4'(`DIP_MIN_CYCLES);

    function automatic logic is_crystal(input rts_pkg::osc_mode_type m);
        is_crystal = (m != rts_pkg::OSC_RES_CAP);
    endfunction

    function automatic logic addr_hit(input logic [`ADDR_W-1:0] a);
        addr_hit = (a == `OFS_POWER_STATUS) || (a == `OFS_CONFIG) ||
            (a == `OFS_SEQ_STATUS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic poweron_s1_ff;
    logic poweron_s2_ff;
    logic supply_low_s1_ff;
    logic supply_low_s2_ff;
    logic clr_n_s1_ff;
    logic clr_n_s2_ff;
    logic clr_n_d_ff;
    logic osc_s1_ff;
    logic osc_s2_ff;
    logic osc_d_ff;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            poweron_s1_ff <= 1'b0;
            poweron_s2_ff <= 1'b0;
            supply_low_s1_ff <= 1'b0;
            supply_low_s2_ff <= 1'b0;
            clr_n_s1_ff <= 1'b1;
            clr_n_s2_ff <= 1'b1;
            clr_n_d_ff <= 1'b1;
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_d_ff <= 1'b0;
        end else begin
            poweron_s1_ff <= POWERON_PULSE_I;
            poweron_s2_ff <= poweron_s1_ff;
            supply_low_s1_ff <= SUPPLY_LOW_I;
            supply_low_s2_ff <= supply_low_s1_ff;
            clr_n_s1_ff <= MASTER_CLEAR_N_I;
            clr_n_s2_ff <= clr_n_s1_ff;
            clr_n_d_ff <= clr_n_s2_ff;
            osc_s1_ff <= OSC_INPUT_PIN_I;
            osc_s2_ff <= osc_s1_ff;
            osc_d_ff <= osc_s2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration and decoded events

    logic [`CFG_W-1:0] config_ff;
    logic [1:0] power_status_ff;
    rts_pkg::seq_state_type state_ff;
    rts_pkg::osc_mode_type osc_mode;
    logic delay_disable;
    logic brownout_en;
    logic osc_rise;
    logic clr_fall;
    logic wake_evt;
    logic wdt_reset_evt;
    logic brownout_trip;
    logic [3:0] dip_cnt_ff;

    assign osc_mode = rts_pkg::osc_mode_type'(
        config_ff[`CFG_MODE_HI:`CFG_MODE_LO]);
    assign delay_disable = config_ff[`CFG_DELAY_DISABLE];
    assign brownout_en = config_ff[`CFG_BROWNOUT_ENABLE];
    assign osc_rise = osc_s2_ff & ~osc_d_ff;
    assign clr_fall = clr_n_d_ff & ~clr_n_s2_ff;
    assign wake_evt = SLEEP_I & (WDT_TIMEOUT_I | INT_WAKE_I);
    assign wdt_reset_evt = ~SLEEP_I & WDT_TIMEOUT_I;

    // a dip must outlast the minimum duration before it trips
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            dip_cnt_ff <= 4'h0;
        end else if (!(supply_low_s2_ff && brownout_en)) begin
            dip_cnt_ff <= 4'h0;
        end else if (dip_cnt_ff != DIP_MIN) begin
            dip_cnt_ff <= dip_cnt_ff + 4'h1;
        end
    end

    assign brownout_trip = brownout_en && supply_low_s2_ff &&
        (dip_cnt_ff == DIP_MIN);

    ////////////////////////////////////////////////////////////////////////
    // sequencer state

    logic [6:0] rc_div_ff;
    logic [16:0] delay_cnt_ff;
    logic [10:0] start_cnt_ff;
    logic rc_tick;
    logic delay_done;
    logic start_done;
    rts_pkg::seq_state_type nxt_state;

    assign rc_tick = (rc_div_ff == RC_TICK_LAST);
    assign delay_done = rc_tick && (delay_cnt_ff == DELAY_LAST);
    assign start_done = osc_rise && (start_cnt_ff == START_LAST);

    always_comb begin
        nxt_state = state_ff;
        if (poweron_s2_ff) begin
            nxt_state = rts_pkg::ST_POWERON;
        end else if (brownout_trip) begin
            nxt_state = rts_pkg::ST_BROWNOUT;
        end else begin
            case (state_ff)
                rts_pkg::ST_POWERON: begin
                    if (!delay_disable) begin
                        nxt_state = rts_pkg::ST_DELAY;
                    end else if (is_crystal(osc_mode)) begin
                        nxt_state = rts_pkg::ST_START;
                    end else begin
                        nxt_state = rts_pkg::ST_RUN;
                    end
                end
                rts_pkg::ST_BROWNOUT: begin
                    if (!supply_low_s2_ff) begin
                        nxt_state = rts_pkg::ST_DELAY;
                    end
                end
                rts_pkg::ST_DELAY: begin
                    if (delay_done && is_crystal(osc_mode)) begin
                        nxt_state = rts_pkg::ST_START;
                    end else if (delay_done) begin
                        nxt_state = rts_pkg::ST_RUN;
                    end
                end
                rts_pkg::ST_START: begin
                    if (start_done) begin
                        nxt_state = rts_pkg::ST_RUN;
                    end
                end
                rts_pkg::ST_RUN: begin
                    if (wake_evt && is_crystal(osc_mode)) begin
                        nxt_state = rts_pkg::ST_START;
                    end
                end
                default: begin
                    nxt_state = rts_pkg::ST_POWERON;
                end
            endcase
        end
    end

    // time-outs advance whatever the master clear pin does
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_ff <= rts_pkg::ST_POWERON;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // internal rc oscillator model, restarted on each delay entry
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            rc_div_ff <= 7'h00;
        end else if (state_ff != rts_pkg::ST_DELAY || rc_tick) begin
            rc_div_ff <= 7'h00;
        end else begin
            rc_div_ff <= rc_div_ff + 7'h01;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            delay_cnt_ff <= 17'h00000;
        end else if (state_ff != rts_pkg::ST_DELAY) begin
            delay_cnt_ff <= 17'h00000;
        end else if (rc_tick && !delay_done) begin
            delay_cnt_ff <= delay_cnt_ff + 17'h00001;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            start_cnt_ff <= 11'h000;
        end else if (state_ff != rts_pkg::ST_START) begin
            start_cnt_ff <= 11'h000;
        end else if (osc_rise && !start_done) begin
            start_cnt_ff <= start_cnt_ff + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chip reset and reset-cause flags

    logic nxt_chip_reset;
    logic timeout_flag_ff;
    logic powerdown_flag_ff;

    assign nxt_chip_reset = poweron_s2_ff || brownout_trip ||
        (nxt_state != rts_pkg::ST_RUN) || !clr_n_s2_ff ||
        wdt_reset_evt;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            CHIP_RESET_O <= 1'b1;
        end else begin
            CHIP_RESET_O <= nxt_chip_reset;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            timeout_flag_ff <= 1'b1;
            powerdown_flag_ff <= 1'b1;
        end else if (poweron_s2_ff || brownout_trip) begin
            timeout_flag_ff <= 1'b1;
            powerdown_flag_ff <= 1'b1;
        end else if (WDT_TIMEOUT_I) begin
            timeout_flag_ff <= 1'b0;
            powerdown_flag_ff <= ~SLEEP_I;
        end else if (wake_evt || (clr_fall && SLEEP_I)) begin
            timeout_flag_ff <= 1'b1;
            powerdown_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            TIMEOUT_FLAG_O <= 1'b1;
            POWERDOWN_FLAG_O <= 1'b1;
        end else begin
            TIMEOUT_FLAG_O <= timeout_flag_ff;
            POWERDOWN_FLAG_O <= powerdown_flag_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave

    logic setup_phase;
    logic wr_commit;
    logic [`DATA_W-1:0] nxt_rdata;

    assign setup_phase = PSEL_I && !PENABLE_I;
    assign wr_commit = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I &&
        PSTRB_I[0] && addr_hit(PADDR_I);

    always_comb begin
        nxt_rdata = '0;
        case (PADDR_I)
            `OFS_POWER_STATUS: begin
                nxt_rdata[1:0] = power_status_ff;
            end
            `OFS_CONFIG: begin
                nxt_rdata[`CFG_W-1:0] = config_ff;
            end
            `OFS_SEQ_STATUS: begin
                nxt_rdata[`STS_TIMEOUT] = timeout_flag_ff;
                nxt_rdata[`STS_POWERDOWN] = powerdown_flag_ff;
                nxt_rdata[`STS_CHIP_RESET] = CHIP_RESET_O;
                nxt_rdata[`STS_DELAY_RUN] = (state_ff == rts_pkg::ST_DELAY);
                nxt_rdata[`STS_START_RUN] = (state_ff == rts_pkg::ST_START);
                nxt_rdata[`STS_BROWNOUT] =
                    (state_ff == rts_pkg::ST_BROWNOUT);
                nxt_rdata[`STS_CLEAR_LOW] = ~clr_n_s2_ff;
            end
            default: begin
                nxt_rdata = '0;
            end
        endcase
    end

    // answer in the first access cycle; data captured at setup
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= '0;
        end else begin
            PREADY_O <= setup_phase;
            PSLVERR_O <= setup_phase && !addr_hit(PADDR_I);
            if (setup_phase && !PWRITE_I) begin
                PRDATA_O <= nxt_rdata;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            config_ff <= `RST_CONFIG;
        end else if (wr_commit && PADDR_I == `OFS_CONFIG) begin
            config_ff <= PWDATA_I[`CFG_W-1:0];
        end
    end

    // hardware clears beat a software set in the same cycle
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            power_status_ff <= `RST_POWER_STATUS;
        end else begin
            if (poweron_s2_ff) begin
                power_status_ff[`BIT_POWERON_STATUS] <= 1'b0;
            end else if (wr_commit && PADDR_I == `OFS_POWER_STATUS) begin
                power_status_ff[`BIT_POWERON_STATUS] <=
                    PWDATA_I[`BIT_POWERON_STATUS];
            end
            if (brownout_trip) begin
                power_status_ff[`BIT_BROWNOUT_STATUS] <= 1'b0;
            end else if (wr_commit && PADDR_I == `OFS_POWER_STATUS) begin
                power_status_ff[`BIT_BROWNOUT_STATUS] <=
                    PWDATA_I[`BIT_BROWNOUT_STATUS];
            end
        end
    end

endmodule

/* File: src/rts_consts.svh */
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 32

`define OFS_POWER_STATUS 8'h00
`define OFS_CONFIG 8'h04
`define OFS_SEQ_STATUS 8'h08

`define BIT_BROWNOUT_STATUS 0
`define BIT_POWERON_STATUS 1

`define CFG_W 4
`define CFG_DELAY_DISABLE 0
`define CFG_BROWNOUT_ENABLE 1
`define CFG_MODE_LO 2
`define CFG_MODE_HI 3

`define STS_TIMEOUT 0
`define STS_POWERDOWN 1
`define STS_CHIP_RESET 2
`define STS_DELAY_RUN 3
`define STS_START_RUN 4
`define STS_BROWNOUT 5
`define STS_CLEAR_LOW 6

`define RST_POWER_STATUS 2'h0
`define RST_CONFIG 4'hc

`define CLK_PERIOD_NS 10
`define DELAY_TIME_MS 72
`define RC_TICK_NS 1000
`define RC_TICK_CYCLES (`RC_TICK_NS / `CLK_PERIOD_NS)
`define DELAY_TICKS (`DELAY_TIME_MS * 1000000 / `RC_TICK_NS)
`define START_CYCLES 1024
`define DIP_MIN_NS 100
`define DIP_MIN_CYCLES ((`DIP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: src/rts_pkg.sv */
// types shared by the reset time-out sequencer
package rts_pkg;

    typedef enum logic [1:0] {
        OSC_LOW_POWER,
        OSC_CRYSTAL,
        OSC_HIGH_SPEED,
        OSC_RES_CAP
    } osc_mode_type;

    typedef enum logic [2:0] {
        ST_POWERON,
        ST_BROWNOUT,
        ST_DELAY,
        ST_START,
        ST_RUN
    } seq_state_type;

endpackage

/* File: tb/rts_checker.sv */
// port assertions for the reset time-out sequencer
`include "rts_consts.svh"
module rts_checker #(
    parameter int unsigned DELAY_TICKS = `DELAY_TICKS
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic POWERON_PULSE_I,
    input wire logic MASTER_CLEAR_N_I,
    input wire logic SLEEP_I,
    input wire logic WDT_TIMEOUT_I,
    input wire logic INT_WAKE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [`ADDR_W-1:0] PADDR_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CHIP_RESET_O,
    input wire logic TIMEOUT_FLAG_O,
    input wire logic POWERDOWN_FLAG_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    a_reset_state: assert property ($rose(RST_N_I) |-> CHIP_RESET_O
        && TIMEOUT_FLAG_O && POWERDOWN_FLAG_O && !PREADY_O)
        else $error("state after reset wrong");
    a_pulse_holds: assert property (POWERON_PULSE_I [*6] |-> CHIP_RESET_O)
        else $error("no reset during power-on pulse");
    a_pulse_flags: assert property (POWERON_PULSE_I [*6] |->
        TIMEOUT_FLAG_O && POWERDOWN_FLAG_O)
        else $error("flags not set by power-on");
    a_clear_holds: assert property (!MASTER_CLEAR_N_I [*5] |-> CHIP_RESET_O)
        else $error("no reset while master clear low");
    a_release_pin: assert property ($fell(CHIP_RESET_O) |->
        $past(MASTER_CLEAR_N_I, 3))
        else $error("reset released with master clear low");
    a_wdt_reset: assert property (WDT_TIMEOUT_I && !SLEEP_I && !CHIP_RESET_O
        |-> ##[1:3] CHIP_RESET_O)
        else $error("watchdog gave no reset");
    a_wdt_flags: assert property (WDT_TIMEOUT_I && !SLEEP_I && !CHIP_RESET_O
        |-> ##[1:4] (!TIMEOUT_FLAG_O && POWERDOWN_FLAG_O))
        else $error("watchdog reset flags wrong");
    a_wake_flags: assert property (INT_WAKE_I && SLEEP_I && !CHIP_RESET_O
        |-> ##[1:4] (TIMEOUT_FLAG_O && !POWERDOWN_FLAG_O))
        else $error("interrupt wake flags wrong");
    a_ready_next: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready after setup");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_map_error: assert property (PREADY_O |-> PSLVERR_O == !(PADDR_I inside
        {`OFS_POWER_STATUS, `OFS_CONFIG, `OFS_SEQ_STATUS}))
        else $error("error response does not match address");
endmodule

bind reset_timeout_sequencer rts_checker #(.DELAY_TICKS(DELAY_TICKS)) u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .POWERON_PULSE_I(POWERON_PULSE_I), .MASTER_CLEAR_N_I(MASTER_CLEAR_N_I),
    .SLEEP_I(SLEEP_I), .WDT_TIMEOUT_I(WDT_TIMEOUT_I),
    .INT_WAKE_I(INT_WAKE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PADDR_I(PADDR_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .CHIP_RESET_O(CHIP_RESET_O), .TIMEOUT_FLAG_O(TIMEOUT_FLAG_O),
    .POWERDOWN_FLAG_O(POWERDOWN_FLAG_O)
);

/* File: tb/testbench.sv */
// self-checking bench of the reset time-out sequencer
`include "rts_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICKS = 5;
    logic clk = 0, rst_n = 0, por = 0, low = 0, clr_n = 1, osc = 0;
    logic slp = 0, wdt = 0, iwk = 0, psel = 0, pen = 0, pwr = 0;
    logic [`ADDR_W-1:0] pa = 0;
    logic [`DATA_W-1:0] pwd = 0, rd, prdata;
    logic [15:0] seed = 16'h4c15;
    logic err, pready, pslverr, crst, tof, pdf;
    logic [3:0] cfgs [6] = '{4'hc, 4'h0, 4'h4, 4'h8, 4'h5, 4'hd};
    int num_errors = 0, check_count = 0, dur;
    reset_timeout_sequencer #(.DELAY_TICKS(TICKS)) u_reset_timeout_sequencer (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .POWERON_PULSE_I(por),
        .SUPPLY_LOW_I(low), .MASTER_CLEAR_N_I(clr_n),
        .OSC_INPUT_PIN_I(osc), .SLEEP_I(slp), .WDT_TIMEOUT_I(wdt),
        .INT_WAKE_I(iwk), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(4'hf), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CHIP_RESET_O(crst),
        .TIMEOUT_FLAG_O(tof), .POWERDOWN_FLAG_O(pdf)
    );
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) osc <= ~osc;
    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // reset length in cycles for a config value
    function automatic int exp_dur(input logic [3:0] c);
        int d;
        d = c[`CFG_DELAY_DISABLE] ? 0 : TICKS * `RC_TICK_CYCLES;
        if (c[`CFG_MODE_HI:`CFG_MODE_LO] != 2'h3)
            d += 2 * `START_CYCLES;
        return d;
    endfunction
    // allows for synchroniser latency
    function automatic logic near(input int v, input int e);
        return v >= e && v <= e + 16;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [`ADDR_W-1:0] a,
            input logic [`DATA_W-1:0] d);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        check(pready, 1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [`ADDR_W-1:0] a,
            input logic [`DATA_W-1:0] e);
        apb(0, a, 0);
        check(rd, e);
    endtask
    task automatic wait_rel(input int lim);
        dur = 0;
        while (crst === 1'b1 && dur < lim) begin
            @(posedge clk);
            dur++;
        end
    endtask
    task automatic pulse();
        por <= 1;
        repeat (8) @(posedge clk);
        por <= 0;
        @(posedge clk);
    endtask
    task automatic dip(input int n);
        low <= 1;
        repeat (n) @(posedge clk);
        low <= 0;
        @(posedge clk);
    endtask
    task automatic wake();
        slp <= 1;
        @(posedge clk);
        iwk <= 1;
        @(posedge clk);
        iwk <= 0;
        slp <= 0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wdog(input logic s);
        slp <= s;
        wdt <= 1;
        @(posedge clk);
        wdt <= 0;
        slp <= 0;
        repeat (4) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        wait_rel(3000);
        check(near(dur, exp_dur(`RST_CONFIG)), 1);
        rd_chk(`OFS_POWER_STATUS, `RST_POWER_STATUS);
        rd_chk(`OFS_CONFIG, `RST_CONFIG);
        rd_chk(`OFS_SEQ_STATUS, 32'h3);
        apb(0, 8'h0c, 0);
        check(err, 1);
        seed = lfsr(seed);
        apb(1, `OFS_POWER_STATUS, 32'(seed));
        rd_chk(`OFS_POWER_STATUS, seed[1:0]);
        apb(1, `OFS_SEQ_STATUS, '1);
        rd_chk(`OFS_SEQ_STATUS, 32'h3);
        for (int i = 0; i < 6; i++) begin
            apb(1, `OFS_POWER_STATUS, 32'h3);
            apb(1, `OFS_CONFIG, cfgs[i]);
            pulse();
            wait_rel(3000);
            check(near(dur, exp_dur(cfgs[i])), 1);
            rd_chk(`OFS_POWER_STATUS, 32'h1);
            check({tof, pdf}, 2'h3);
        end
        apb(1, `OFS_CONFIG, 4'hc);
        clr_n <= 0;
        pulse();
        repeat (600) @(posedge clk);
        check(crst, 1);
        clr_n <= 1;
        @(posedge clk);
        wait_rel(50);
        check(near(dur, 0), 1);
        apb(1, `OFS_CONFIG, 4'he);
        apb(1, `OFS_POWER_STATUS, 32'h3);
        seed = lfsr(seed);
        dip(int'(seed[2:0]) + 1);
        repeat (20) @(posedge clk);
        check(crst, 0);
        dip(30);
        check(crst, 1);
        repeat (200) @(posedge clk);
        dip(30);
        wait_rel(3000);
        check(near(dur, exp_dur(4'hc)), 1);
        rd_chk(`OFS_POWER_STATUS, 32'h2);
        apb(1, `OFS_CONFIG, 4'hc);
        dip(40);
        check(crst, 0);
        apb(1, `OFS_CONFIG, 4'h4);
        wake();
        check(crst, 1);
        check({tof, pdf}, 2'h2);
        rd_chk(`OFS_SEQ_STATUS, 32'h15);
        wait_rel(3000);
        check(near(dur + 8, 2 * `START_CYCLES), 1);
        apb(1, `OFS_CONFIG, 4'hc);
        wake();
        check(crst, 0);
        wdog(0);
        check({tof, pdf}, 2'h1);
        wdog(1);
        check({tof, pdf}, 2'h0);
        clr_n <= 0;
        repeat (10) @(posedge clk);
        check(crst, 1);
        clr_n <= 1;
        @(posedge clk);
        wait_rel(50);
        check({tof, pdf}, 2'h0);
        slp <= 1;
        clr_n <= 0;
        repeat (6) @(posedge clk);
        slp <= 0;
        clr_n <= 1;
        repeat (6) @(posedge clk);
        check({tof, pdf}, 2'h2);
        summarize();
    end
endmodule
